/* File: rtl/drive_io_pkg.sv */
// constants, codes and types shared by the drive i/o, jog and halt logic
package drive_io_pkg;

  // parameter addresses
  localparam logic [15:0] ADDR_REF_POL = 16'h061c;
  localparam logic [15:0] ADDR_NEG_POL = 16'h061e;
  localparam logic [15:0] ADDR_POS_POL = 16'h0620;
  localparam logic [15:0] ADDR_HALT_TYPE = 16'h062e;
  localparam logic [15:0] ADDR_PIN_TWO = 16'h0724;
  localparam logic [15:0] ADDR_PIN_THREE = 16'h0726;
  localparam logic [15:0] ADDR_PIN_FOUR = 16'h0728;
  localparam logic [15:0] ADDR_OUT_BITS = 16'h0822;
  localparam logic [15:0] ADDR_JOG_REQ = 16'h2900;
  localparam logic [15:0] ADDR_JOG_SLOW = 16'h2908;
  localparam logic [15:0] ADDR_JOG_FAST = 16'h290a;
  localparam logic [15:0] ADDR_JOG_STEP = 16'h290e;
  localparam logic [15:0] ADDR_JOG_WAIT = 16'h2910;

  // values after reset
  localparam logic [15:0] RST_REF_POL = 16'h0001;
  localparam logic [15:0] RST_NEG_POL = 16'h0001;
  localparam logic [15:0] RST_POS_POL = 16'h0001;
  localparam logic [15:0] RST_HALT_TYPE = 16'h0003;
  localparam logic [15:0] RST_PIN_FUNC = 16'h0000;
  localparam logic [15:0] RST_OUT_BITS = 16'h0000;
  localparam logic [15:0] RST_JOG_REQ = 16'h0000;
  localparam logic [15:0] RST_JOG_SLOW = 16'h003c;
  localparam logic [15:0] RST_JOG_FAST = 16'h00b4;
  localparam logic [31:0] RST_JOG_STEP = 32'h00000001;
  localparam logic [15:0] RST_JOG_WAIT = 16'h01f4;

  // pin function codes
  localparam logic [15:0] FN_NONE = 16'h0000;
  localparam logic [15:0] FN_FREE_IN = 16'h0001;
  localparam logic [15:0] FN_FAULT_RESET = 16'h0002;
  localparam logic [15:0] FN_ENABLE = 16'h0003;
  localparam logic [15:0] FN_HALT = 16'h0004;
  localparam logic [15:0] FN_JOG_POS = 16'h0009;
  localparam logic [15:0] FN_JOG_NEG = 16'h000a;
  localparam logic [15:0] FN_JOG_FAST = 16'h000b;
  localparam logic [15:0] FN_REF_SWITCH = 16'h0014;
  localparam logic [15:0] FN_NEG_LIMIT = 16'h0016;
  localparam logic [15:0] FN_FREE_OUT = 16'h0065;
  localparam logic [15:0] FN_NO_FAULT_OUT = 16'h0066;
  localparam logic [15:0] FN_READY_OUT = 16'h0067;

  // switch evaluation and halt codes
  localparam logic [15:0] POL_INACTIVE = 16'h0000;
  localparam logic [15:0] POL_NC = 16'h0001;
  localparam logic [15:0] POL_NO = 16'h0002;
  localparam logic [15:0] HALT_DECEL_RAMP = 16'h0001;
  localparam logic [15:0] HALT_TORQUE_RAMP = 16'h0003;

  // value ranges
  localparam logic [15:0] SPEED_MIN = 16'h0001;
  localparam logic [15:0] SPEED_MAX = 16'h3390;
  localparam logic [15:0] WAIT_MIN = 16'h0001;
  localparam logic [15:0] WAIT_MAX = 16'h7fff;
  localparam logic [31:0] STEP_MAX = 32'h7fffffff;
  localparam logic [15:0] JOG_REQ_MAX = 16'h0007;

  // bit positions
  localparam int JOG_BIT_POS = 0;
  localparam int JOG_BIT_NEG = 1;
  localparam int JOG_BIT_FAST = 2;
  localparam int OUT_BIT_FIRST = 0;
  localparam int OUT_BIT_SECOND = 1;

  // timing
  localparam int CLOCK_PERIOD_NS = 20;
  localparam int NS_PER_MS = 1000000;
  localparam int MS_CYCLES_DEFAULT = NS_PER_MS / CLOCK_PERIOD_NS;

  typedef enum logic [3:0] {
    JOG_IDLE = 4'b0001,
    JOG_STEP = 4'b0010,
    JOG_WAIT = 4'b0100,
    JOG_RUN = 4'b1000
  } jog_state_e;

endpackage

/* File: rtl/pin_function_decode.sv */
// function decode, input synchroniser and output drive of one multipurpose pin
`timescale 1ns/1ns
module pin_function_decode
  import drive_io_pkg::*;
#(
  parameter bit ALLOW_NEG_LIMIT = 1'b0
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic pinIn,
  input wire logic [15:0] funcCode,
  input wire logic localMode,
  input wire logic freeOutBit,
  input wire logic noFault,
  input wire logic ready,
  output logic pinOut,
  output logic pinOe,
  output logic level,
  output logic actFaultReset,
  output logic actEnable,
  output logic actHalt,
  output logic actJogPos,
  output logic actJogNeg,
  output logic actJogFast,
  output logic selRef,
  output logic selNegLimit
);

  logic syncA_q;
  logic syncB_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
    end else begin
      syncA_q <= pinIn;
      syncB_q <= syncA_q;
    end
  end

  assign level = syncB_q;
  assign selRef = (funcCode == FN_REF_SWITCH);
  assign selNegLimit = ALLOW_NEG_LIMIT && (funcCode == FN_NEG_LIMIT);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      actFaultReset <= 1'b0;
      actEnable <= 1'b0;
      actHalt <= 1'b0;
      actJogPos <= 1'b0;
      actJogNeg <= 1'b0;
      actJogFast <= 1'b0;
      pinOut <= 1'b0;
      pinOe <= 1'b0;
    end else begin
      actFaultReset <= syncB_q && localMode && (funcCode == FN_FAULT_RESET);
      actEnable <= syncB_q && localMode && (funcCode == FN_ENABLE);
      actHalt <= syncB_q && (funcCode == FN_HALT);
      actJogPos <= syncB_q && (funcCode == FN_JOG_POS);
      actJogNeg <= syncB_q && (funcCode == FN_JOG_NEG);
      actJogFast <= syncB_q && (funcCode == FN_JOG_FAST);
      pinOe <= (funcCode >= FN_FREE_OUT) && (funcCode <= FN_READY_OUT);
      pinOut <= ((funcCode == FN_FREE_OUT) && freeOutBit) ||
                ((funcCode == FN_NO_FAULT_OUT) && noFault) ||
                ((funcCode == FN_READY_OUT) && ready);
    end
  end

  a_local_only: assert property (@(posedge core_clk) disable iff (reset)
    !localMode |=> !actEnable && !actFaultReset)
    else $error("enable or fault reset acted outside local mode");

  a_free_output: assert property (@(posedge core_clk) disable iff (reset)
    funcCode == FN_FREE_OUT && $stable(funcCode) |=> pinOe && pinOut == $past(freeOutBit))
    else $error("free output pin does not follow its direct bit");

endmodule

/* File: rtl/drive_io_jog_halt_config.sv */
// parameter registers, switch evaluation, jog sequencing and halt selection
// Contract
// - pin two accepts listed codes incl. negative limit
// - fault reset and enable act in local mode
// - pins three, four accept codes without limit
// - negative limit: off, NC, NO; default NC
// - positive limit: off, NC, NO; nothing above two
// - reference switch: NC or NO only, default NC
// - reference switch evaluated only during homing
// - jog word: bit0 positive, bit1 negative, bit2 fast
// - both directions from idle start nothing
// - both directions while running change nothing
// - fast speed 1..13200, default 180, clamped
// - slow speed 1..13200, default 60, clamped
// - step distance zero continuous, positive steps
// - nonzero step waits 1..32767 ms before run
// - zero step ignores wait, runs at once
// - halt type one decel ramp, three torque
// - ramp from deceleration, torque from halt current
// - decel ramp only with profile generator
// - direct output bits only drive free outputs
`timescale 1ns/1ns
module drive_io_jog_halt_config
  import drive_io_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEFAULT
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [15:0] paramAddr,
  input wire logic paramWrite,
  input wire logic paramRead,
  input wire logic [31:0] paramWrData,
  output logic [31:0] paramRdData,
  output logic paramAck,
  output logic paramReject,
  input wire logic [2:0] multiPinIn,
  output logic [2:0] multiPinOut,
  output logic [2:0] multiPinOe,
  input wire logic positiveEndSwitchIn,
  input wire logic firstOutputIsFree,
  output logic firstOutput,
  input wire logic localMode,
  input wire logic noFault,
  input wire logic driveReady,
  input wire logic homingActive,
  input wire logic profileGenMode,
  input wire logic jogStepDone,
  input wire logic [15:0] maxRampSpeed,
  input wire logic [31:0] decelerationSetting,
  input wire logic [15:0] haltCurrentLimit,
  output logic negLimitHit,
  output logic posLimitHit,
  output logic refSwitchHit,
  output logic faultResetReq,
  output logic enableReq,
  output logic haltReq,
  output logic haltUseDecelRamp,
  output logic [31:0] haltRampValue,
  output logic jogActive,
  output logic jogContinuous,
  output logic jogNegative,
  output logic jogStepStart,
  output logic [31:0] jogStepDistance,
  output logic [15:0] jogSpeed
);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  logic [15:0] refPol_q;
  logic [15:0] negPol_q;
  logic [15:0] posPol_q;
  logic [15:0] haltType_q;
  logic [15:0] pinFunc_q [3];
  logic [15:0] outBits_q;
  logic [15:0] jogReq_q;
  logic [15:0] jogSlow_q;
  logic [15:0] jogFast_q;
  logic [31:0] jogStep_q;
  logic [15:0] jogWait_q;

  logic [31:0] rdMux;
  logic addrHit;
  logic valueOk;

  function automatic logic pin_code_ok(input logic [15:0] c, input logic allowLimit);
    pin_code_ok = (c == FN_NONE) || (c == FN_FREE_IN) || (c == FN_FAULT_RESET) ||
                  (c == FN_ENABLE) || (c == FN_HALT) || (c == FN_JOG_POS) ||
                  (c == FN_JOG_NEG) || (c == FN_JOG_FAST) || (c == FN_REF_SWITCH) ||
                  (allowLimit && (c == FN_NEG_LIMIT)) ||
                  ((c >= FN_FREE_OUT) && (c <= FN_READY_OUT));
  endfunction

  function automatic logic switch_active(input logic [15:0] pol, input logic lvl);
    switch_active = ((pol == POL_NC) && !lvl) || ((pol == POL_NO) && lvl);
  endfunction

  // address decode and value range checks
  always_comb begin
    addrHit = 1'b1;
    valueOk = 1'b1;
    rdMux = 32'h00000000;
    unique case (paramAddr)
      ADDR_REF_POL: begin
        rdMux = {16'h0000, refPol_q};
        valueOk = (paramWrData == {16'h0000, POL_NC}) ||
                  (paramWrData == {16'h0000, POL_NO});
      end
      ADDR_NEG_POL: begin
        rdMux = {16'h0000, negPol_q};
        valueOk = paramWrData <= {16'h0000, POL_NO};
      end
      ADDR_POS_POL: begin
        rdMux = {16'h0000, posPol_q};
        valueOk = paramWrData <= {16'h0000, POL_NO};
      end
      ADDR_HALT_TYPE: begin
        rdMux = {16'h0000, haltType_q};
        valueOk = (paramWrData == {16'h0000, HALT_DECEL_RAMP}) ||
                  (paramWrData == {16'h0000, HALT_TORQUE_RAMP});
      end
      ADDR_PIN_TWO: begin
        rdMux = {16'h0000, pinFunc_q[0]};
        valueOk = (paramWrData[31:16] == 16'h0000) &&
                  pin_code_ok(paramWrData[15:0], 1'b1);
      end
      ADDR_PIN_THREE: begin
        rdMux = {16'h0000, pinFunc_q[1]};
        valueOk = (paramWrData[31:16] == 16'h0000) &&
                  pin_code_ok(paramWrData[15:0], 1'b0);
      end
      ADDR_PIN_FOUR: begin
        rdMux = {16'h0000, pinFunc_q[2]};
        valueOk = (paramWrData[31:16] == 16'h0000) &&
                  pin_code_ok(paramWrData[15:0], 1'b0);
      end
      ADDR_OUT_BITS: begin
        rdMux = {16'h0000, outBits_q};
        valueOk = paramWrData[31:16] == 16'h0000;
      end
      ADDR_JOG_REQ: begin
        rdMux = {16'h0000, jogReq_q};
        valueOk = paramWrData <= {16'h0000, JOG_REQ_MAX};
      end
      ADDR_JOG_SLOW: begin
        rdMux = {16'h0000, jogSlow_q};
        valueOk = (paramWrData >= {16'h0000, SPEED_MIN}) &&
                  (paramWrData <= {16'h0000, SPEED_MAX});
      end
      ADDR_JOG_FAST: begin
        rdMux = {16'h0000, jogFast_q};
        valueOk = (paramWrData >= {16'h0000, SPEED_MIN}) &&
                  (paramWrData <= {16'h0000, SPEED_MAX});
      end
      ADDR_JOG_STEP: begin
        rdMux = jogStep_q;
        valueOk = paramWrData <= STEP_MAX;
      end
      ADDR_JOG_WAIT: begin
        rdMux = {16'h0000, jogWait_q};
        valueOk = (paramWrData >= {16'h0000, WAIT_MIN}) &&
                  (paramWrData <= {16'h0000, WAIT_MAX});
      end
      default: begin
        addrHit = 1'b0;
        valueOk = 1'b0;
      end
    endcase
  end

  // parameter storage; an out-of-range write leaves the old value
  always_ff @(posedge core_clk) begin
    if (reset) begin
      refPol_q <= RST_REF_POL;
      negPol_q <= RST_NEG_POL;
      posPol_q <= RST_POS_POL;
      haltType_q <= RST_HALT_TYPE;
      pinFunc_q[0] <= RST_PIN_FUNC;
      pinFunc_q[1] <= RST_PIN_FUNC;
      pinFunc_q[2] <= RST_PIN_FUNC;
      outBits_q <= RST_OUT_BITS;
      jogReq_q <= RST_JOG_REQ;
      jogSlow_q <= RST_JOG_SLOW;
      jogFast_q <= RST_JOG_FAST;
      jogStep_q <= RST_JOG_STEP;
      jogWait_q <= RST_JOG_WAIT;
    end else if (paramWrite && valueOk) begin
      unique case (paramAddr)
        ADDR_REF_POL: refPol_q <= paramWrData[15:0];
        ADDR_NEG_POL: negPol_q <= paramWrData[15:0];
        ADDR_POS_POL: posPol_q <= paramWrData[15:0];
        ADDR_HALT_TYPE: haltType_q <= paramWrData[15:0];
        ADDR_PIN_TWO: pinFunc_q[0] <= paramWrData[15:0];
        ADDR_PIN_THREE: pinFunc_q[1] <= paramWrData[15:0];
        ADDR_PIN_FOUR: pinFunc_q[2] <= paramWrData[15:0];
        ADDR_OUT_BITS: outBits_q <= paramWrData[15:0];
        ADDR_JOG_REQ: jogReq_q <= paramWrData[15:0];
        ADDR_JOG_SLOW: jogSlow_q <= paramWrData[15:0];
        ADDR_JOG_FAST: jogFast_q <= paramWrData[15:0];
        ADDR_JOG_STEP: jogStep_q <= paramWrData;
        ADDR_JOG_WAIT: jogWait_q <= paramWrData[15:0];
        default: ;
      endcase
    end
  end

  // one answer per strobe, the cycle after it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      paramAck <= 1'b0;
      paramReject <= 1'b0;
      paramRdData <= 32'h00000000;
    end else begin
      paramAck <= (paramWrite && valueOk) || (paramRead && addrHit);
      paramReject <= (paramWrite && !valueOk) || (paramRead && !addrHit);
      if (paramRead) begin
        paramRdData <= rdMux;
      end
    end
  end

  a_pos_range: assert property (
    paramWrite && paramAddr == ADDR_POS_POL && paramWrData > 32'h00000002
    |=> paramReject && !paramAck && $stable(posPol_q))
    else $error("positive limit evaluation took a value above two");

  // multipurpose pins two to four
  logic [2:0] pinLevel;
  logic [2:0] pinFaultReset;
  logic [2:0] pinEnable;
  logic [2:0] pinHalt;
  logic [2:0] pinJogPos;
  logic [2:0] pinJogNeg;
  logic [2:0] pinJogFast;
  logic [2:0] pinSelRef;
  logic [2:0] pinSelNeg;

  for (genvar i = 0; i < 3; i++) begin : g_pin
    pin_function_decode #(
      .ALLOW_NEG_LIMIT(i == 0)
    ) u_pin (
      .core_clk(core_clk),
      .reset(reset),
      .pinIn(multiPinIn[i]),
      .funcCode(pinFunc_q[i]),
      .localMode(localMode),
      .freeOutBit(i == 0 ? outBits_q[OUT_BIT_SECOND] : 1'b0),
      .noFault(noFault),
      .ready(driveReady),
      .pinOut(multiPinOut[i]),
      .pinOe(multiPinOe[i]),
      .level(pinLevel[i]),
      .actFaultReset(pinFaultReset[i]),
      .actEnable(pinEnable[i]),
      .actHalt(pinHalt[i]),
      .actJogPos(pinJogPos[i]),
      .actJogNeg(pinJogNeg[i]),
      .actJogFast(pinJogFast[i]),
      .selRef(pinSelRef[i]),
      .selNegLimit(pinSelNeg[i])
    );
  end

  assign faultResetReq = |pinFaultReset;
  assign enableReq = |pinEnable;
  assign haltReq = |pinHalt;

  // switch evaluation
  logic posSyncA_q;
  logic posSyncB_q;
  logic negPresent;
  logic negLevel;
  logic refPresent;
  logic refLevel;

  assign negPresent = |pinSelNeg;
  assign negLevel = |(pinSelNeg & pinLevel);
  assign refPresent = |pinSelRef;
  assign refLevel = |(pinSelRef & pinLevel);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      posSyncA_q <= 1'b0;
      posSyncB_q <= 1'b0;
      negLimitHit <= 1'b0;
      posLimitHit <= 1'b0;
      refSwitchHit <= 1'b0;
      firstOutput <= 1'b0;
    end else begin
      posSyncA_q <= positiveEndSwitchIn;
      posSyncB_q <= posSyncA_q;
      negLimitHit <= negPresent && switch_active(negPol_q, negLevel);
      posLimitHit <= switch_active(posPol_q, posSyncB_q);
      refSwitchHit <= homingActive && refPresent && switch_active(refPol_q, refLevel);
      firstOutput <= firstOutputIsFree && outBits_q[OUT_BIT_FIRST];
    end
  end

  a_ref_ignored: assert property (
    !homingActive |=> !refSwitchHit)
    else $error("reference switch evaluated outside homing");

  a_neg_inactive: assert property (
    negPol_q == POL_INACTIVE |=> !negLimitHit)
    else $error("inactive negative limit reported a hit");

  // halt reaction
  always_ff @(posedge core_clk) begin
    if (reset) begin
      haltUseDecelRamp <= 1'b0;
      haltRampValue <= 32'h00000000;
    end else begin
      haltUseDecelRamp <= profileGenMode && (haltType_q == HALT_DECEL_RAMP);
      if (profileGenMode && (haltType_q == HALT_DECEL_RAMP)) begin
        haltRampValue <= decelerationSetting;
      end else begin
        haltRampValue <= {16'h0000, haltCurrentLimit};
      end
    end
  end

  a_halt_torque: assert property (
    !profileGenMode |=> !haltUseDecelRamp && haltRampValue == {16'h0000, $past(haltCurrentLimit)})
    else $error("deceleration ramp chosen without profile generator");

  // jog sequencing
  jog_state_e jogState_q;
  logic reqPos;
  logic reqNeg;
  logic reqFast;
  logic held;
  logic msTick;
  logic [31:0] msPre_q;
  logic [15:0] msCount_q;

  assign reqPos = jogReq_q[JOG_BIT_POS] || (|pinJogPos);
  assign reqNeg = jogReq_q[JOG_BIT_NEG] || (|pinJogNeg);
  assign reqFast = jogReq_q[JOG_BIT_FAST] || (|pinJogFast);
  assign held = jogNegative ? reqNeg : reqPos;
  assign msTick = msPre_q == 32'(MS_CYCLES - 1);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      jogState_q <= JOG_IDLE;
      jogNegative <= 1'b0;
      jogStepStart <= 1'b0;
    end else begin
      jogStepStart <= 1'b0;
      unique case (jogState_q)
        JOG_IDLE: begin
          if ((reqPos != reqNeg) && !haltReq) begin
            jogNegative <= reqNeg;
            if (jogStep_q == 32'h00000000) begin
              jogState_q <= JOG_RUN;
            end else begin
              jogState_q <= JOG_STEP;
              jogStepStart <= 1'b1;
            end
          end
        end
        JOG_STEP: begin
          if (!held || haltReq) begin
            jogState_q <= JOG_IDLE;
          end else if (jogStepDone) begin
            jogState_q <= JOG_WAIT;
          end
        end
        JOG_WAIT: begin
          if (!held || haltReq) begin
            jogState_q <= JOG_IDLE;
          end else if (msCount_q >= jogWait_q) begin
            jogState_q <= JOG_RUN;
          end
        end
        JOG_RUN: begin
          if (!held || haltReq) begin
            jogState_q <= JOG_IDLE;
          end
        end
      endcase
    end
  end

  // millisecond timebase, restarted whenever the wait phase is left
  always_ff @(posedge core_clk) begin
    if (reset) begin
      msPre_q <= 32'h00000000;
      msCount_q <= 16'h0000;
    end else if (jogState_q != JOG_WAIT) begin
      msPre_q <= 32'h00000000;
      msCount_q <= 16'h0000;
    end else if (msTick) begin
      msPre_q <= 32'h00000000;
      msCount_q <= msCount_q + 16'h0001;
    end else begin
      msPre_q <= msPre_q + 32'h00000001;
    end
  end

  // speed and step outputs, speed clamped to the ramp maximum
  always_ff @(posedge core_clk) begin
    if (reset) begin
      jogSpeed <= 16'h0000;
      jogStepDistance <= RST_JOG_STEP;
    end else begin
      jogStepDistance <= jogStep_q;
      if (reqFast) begin
        jogSpeed <= (jogFast_q > maxRampSpeed) ? maxRampSpeed : jogFast_q;
      end else begin
        jogSpeed <= (jogSlow_q > maxRampSpeed) ? maxRampSpeed : jogSlow_q;
      end
    end
  end

  assign jogActive = jogState_q != JOG_IDLE;
  assign jogContinuous = jogState_q == JOG_RUN;

  a_both_idle: assert property (
    jogState_q == JOG_IDLE && reqPos && reqNeg |=> jogState_q == JOG_IDLE && !jogStepStart)
    else $error("movement started with both directions requested");

  a_both_running: assert property (
    jogState_q == JOG_RUN && reqPos && reqNeg && !haltReq
    |=> jogState_q == JOG_RUN && $stable(jogNegative))
    else $error("running jog changed on both directions");

  a_zero_step: assert property (
    jogState_q == JOG_IDLE && reqPos != reqNeg && !haltReq && jogStep_q == 32'h00000000
    |=> jogContinuous && !jogStepStart)
    else $error("zero step did not start continuous run");

  a_step_first: assert property (
    jogState_q == JOG_IDLE && reqPos != reqNeg && !haltReq && jogStep_q != 32'h00000000
    |=> jogState_q == JOG_STEP && jogStepStart)
    else $error("nonzero step did not start with one step");

  a_wait_time: assert property (
    jogState_q == JOG_RUN && $past(jogState_q) == JOG_WAIT |-> $past(msCount_q) >= $past(jogWait_q))
    else $error("continuous run began before the wait time");

  a_release_stop: assert property (
    jogActive && !held |=> !jogActive)
    else $error("jog kept moving after the request was cleared");

  a_speed_clamp: assert property (
    1'b1 |=> jogSpeed <= $past(maxRampSpeed))
    else $error("jog speed above the ramp maximum");

endmodule

/* File: sim/switch_field_model.sv */
// field switches and profile generator step response facing the drive block
`timescale 1ns/1ns
module switch_field_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic posSwitchClosed,
  input wire logic [2:0] pinLevels,
  input wire logic jogStepStart,
  output logic positiveEndSwitchIn,
  output logic [2:0] multiPinIn,
  output logic jogStepDone
);
  logic [3:0] stepCnt_q;
  // a closed contact pulls the line high
  assign positiveEndSwitchIn = posSwitchClosed;
  assign multiPinIn = pinLevels;
  // the step move takes a few cycles before it reports done
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stepCnt_q <= 4'h0;
    end else if (jogStepStart) begin
      stepCnt_q <= 4'h6;
    end else if (stepCnt_q != 4'h0) begin
      stepCnt_q <= stepCnt_q - 4'h1;
    end
  end
  assign jogStepDone = (stepCnt_q == 4'h1);
endmodule

/* File: sim/tb_top.sv */
// self-checking testbench of the drive i/o, jog and halt configuration block
`timescale 1ns/1ns
module tb_top;
  import drive_io_pkg::*;
  logic core_clk, reset, paramWrite, paramRead, paramAck, paramReject, posSw, pgMode;
  logic jogStepDone, jogStepStart, posLimitHit, haltUse, jogActive, jogCont, jogNeg;
  logic ackSeen, rejSeen, pinEnd, fOutFree, locMode, homing, fOut, enReq, refHit;
  logic [2:0] pinIn, pinLevels, pinOut, pinOe;
  logic [15:0] paramAddr, jogSpeed, rampMax;
  logic [31:0] paramWrData, paramRdData, rdSeen, haltRampValue;
  int miscompares = 0;
  int cmp_count = 0;
  drive_io_jog_halt_config #(.MS_CYCLES(5)) drive_io_jog_halt_config_i (
    .core_clk(core_clk), .reset(reset), .paramAddr(paramAddr), .paramWrite(paramWrite),
    .paramRead(paramRead), .paramWrData(paramWrData), .paramRdData(paramRdData),
    .paramAck(paramAck), .paramReject(paramReject), .multiPinIn(pinIn),
    .multiPinOut(pinOut), .multiPinOe(pinOe), .positiveEndSwitchIn(pinEnd),
    .firstOutputIsFree(fOutFree), .firstOutput(fOut), .localMode(locMode),
    .noFault(1'b1), .driveReady(1'b1), .homingActive(homing), .profileGenMode(pgMode),
    .jogStepDone(jogStepDone), .maxRampSpeed(rampMax), .decelerationSetting(32'h00001234),
    .haltCurrentLimit(16'h0abc), .negLimitHit(), .posLimitHit(posLimitHit),
    .refSwitchHit(refHit), .faultResetReq(), .enableReq(enReq), .haltReq(),
    .haltUseDecelRamp(haltUse), .haltRampValue(haltRampValue), .jogActive(jogActive),
    .jogContinuous(jogCont), .jogNegative(jogNeg), .jogStepStart(jogStepStart),
    .jogStepDistance(), .jogSpeed(jogSpeed)
  );
  switch_field_model switch_field_model_i (
    .core_clk(core_clk), .reset(reset), .posSwitchClosed(posSw), .pinLevels(pinLevels),
    .jogStepStart(jogStepStart), .positiveEndSwitchIn(pinEnd), .multiPinIn(pinIn),
    .jogStepDone(jogStepDone)
  );
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one strobe cycle, answer captured, then one idle cycle
  task automatic acc(input logic wr, input logic [15:0] a, input logic [31:0] d);
    paramAddr = a;
    paramWrData = d;
    paramWrite = wr;
    paramRead = !wr;
    @(posedge core_clk);
    #1;
    paramWrite = 1'b0;
    paramRead = 1'b0;
    ackSeen = paramAck;
    rejSeen = paramReject;
    rdSeen = paramRdData;
    @(posedge core_clk);
    #1;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic t_defaults;
    logic [15:0] adr [9] = '{16'h061c, 16'h061e, 16'h0620, 16'h062e, 16'h0724,
                             16'h2908, 16'h290a, 16'h2910, 16'h290e};
    logic [31:0] exv [9] = '{32'h1, 32'h1, 32'h1, 32'h3, 32'h0, 32'h3c, 32'hb4, 32'h1f4,
                             32'h1};
    for (int i = 0; i < 9; i++) begin
      acc(1'b0, adr[i], 32'h0);
      chk(rdSeen, exv[i]);
    end
    acc(1'b0, 16'h0700, 32'h0);
    chk(rejSeen, 1'b1);
    $display("test defaults done");
  endtask
  task automatic t_ranges;
    acc(1'b1, 16'h0620, 32'h3);
    chk(rejSeen, 1'b1);
    acc(1'b1, 16'h061c, 32'h0);
    chk(rejSeen, 1'b1);
    acc(1'b1, 16'h0724, 32'h16);
    chk(ackSeen, 1'b1);
    acc(1'b1, 16'h0726, 32'h16);
    chk(rejSeen, 1'b1);
    acc(1'b1, 16'h0728, 32'h67);
    chk(ackSeen, 1'b1);
    acc(1'b1, 16'h290a, 32'h3391);
    chk(rejSeen, 1'b1);
    $display("test ranges done");
  endtask
  task automatic t_jog_run;
    acc(1'b1, 16'h290e, 32'h0);
    acc(1'b1, 16'h2900, 32'h1);
    chk(jogCont, 1'b1);
    chk(jogNeg, 1'b0);
    acc(1'b1, 16'h2900, 32'h3);
    chk({jogActive, jogNeg}, 2'b10);
    acc(1'b1, 16'h2900, 32'h0);
    acc(1'b1, 16'h2900, 32'h3);
    cyc(2);
    chk(jogActive, 1'b0);
    $display("test jog run done");
  endtask
  task automatic t_jog_step;
    int n;
    acc(1'b1, 16'h2900, 32'h0);
    acc(1'b1, 16'h290e, 32'h4);
    acc(1'b1, 16'h2910, 32'h2);
    acc(1'b1, 16'h2900, 32'h6);
    chk({jogActive, jogCont, jogNeg}, 3'b101);
    chk(jogSpeed, 16'h0064);
    cyc(8);
    chk(jogCont, 1'b0);
    n = 0;
    while (jogCont !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    chk(jogCont, 1'b1);
    acc(1'b1, 16'h2900, 32'h0);
    cyc(1);
    chk(jogActive, 1'b0);
    rampMax = 16'h0020;
    cyc(2);
    chk(jogSpeed, 16'h0020);
    rampMax = 16'h0200;
    cyc(2);
    chk(jogSpeed, 16'h003c);
    $display("test jog step done");
  endtask
  task automatic t_halt_limit;
    pgMode = 1'b1;
    acc(1'b1, 16'h062e, 32'h1);
    cyc(1);
    chk({haltUse, haltRampValue[30:0]}, {1'b1, 31'h1234});
    pgMode = 1'b0;
    cyc(2);
    chk({haltUse, haltRampValue[30:0]}, {1'b0, 31'h0abc});
    acc(1'b1, 16'h0620, 32'h2);
    posSw = 1'b1;
    cyc(6);
    chk(posLimitHit, 1'b1);
    acc(1'b1, 16'h0620, 32'h0);
    cyc(2);
    chk(posLimitHit, 1'b0);
    $display("test halt and limit done");
  endtask
  task automatic t_pins;
    fOutFree = 1'b1;
    acc(1'b1, 16'h0822, 32'h3);
    acc(1'b1, 16'h0724, 32'h65);
    chk({fOut, pinOe[0], pinOut[0], pinOe[2], pinOut[2]}, 5'h1f);
    acc(1'b1, 16'h0822, 32'h1);
    chk({fOut, pinOut[0]}, 2'b10);
    acc(1'b1, 16'h0726, 32'h3);
    pinLevels = 3'b010;
    cyc(4);
    chk(enReq, 1'b1);
    locMode = 1'b0;
    cyc(2);
    chk(enReq, 1'b0);
    locMode = 1'b1;
    acc(1'b1, 16'h0726, 32'h14);
    pinLevels = 3'b000;
    cyc(4);
    chk(refHit, 1'b0);
    homing = 1'b1;
    cyc(2);
    chk(refHit, 1'b1);
    $display("test pins done");
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    {paramWrite, paramRead, posSw, pgMode, fOutFree, homing} = 6'h00;
    locMode = 1'b1;
    rampMax = 16'h0064;
    pinLevels = 3'h0;
    paramAddr = 16'h0;
    paramWrData = 32'h0;
    cyc(4);
    reset = 1'b0;
    t_defaults();
    t_ranges();
    t_jog_run();
    t_jog_step();
    t_halt_limit();
    t_pins();
    results();
  end
  initial begin
    #100000;
    miscompares++;
    results();
  end
endmodule
